/* File: rtl/switch_latch_pkg.sv */
package switch_latch_pkg;

  // ==========================================================
  // array shape
  localparam int unsigned CHANNELS    = 32;
  localparam int unsigned FIRST_STAGE = 0;
  localparam int unsigned LAST_STAGE  = 31;

  // ==========================================================
  // buffering
  localparam int unsigned FIFO_WIDTH  = 1;
  localparam int unsigned FIFO_DEPTH  = 4;

  // ==========================================================
  // reset values
  localparam logic [31:0] SHIFT_RESET  = 32'h0000_0000;
  localparam logic [31:0] LATCH_RESET  = 32'h0000_0000;
  localparam logic [31:0] SWITCH_RESET = 32'h0000_0000;
  localparam logic [4:0]  COUNT_RESET  = 5'h00;

endpackage

/* File: rtl/bit_fifo.sv */
`timescale 1ns/100ps
module bit_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic [AW:0]      nxt_wr_ptr;
  logic [AW:0]      nxt_rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  always_comb
  begin
    fill       = wr_ptr_ff - rd_ptr_ff;
    in_ready   = (fill != (AW+1)'(DEPTH));
    out_valid  = (fill != '0);
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    out_data   = mem_ff[rd_ptr_ff[AW-1:0]];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else if (clk_en)
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clk_en && push)
    begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

endmodule

/* File: rtl/serial_switch_latch_control.sv */
// Operation
// - mode low: switches come from 32-bit shift register then 32-bit latch
// - latched one turns its channel on, latched zero turns it off
// - mode high: serial input high turns all on, low turns all off
// - shift only on serial clock rising edge, never on falling edge
// - new bits enter stage 0 and move toward stage 31
// - first bit in stage 0 after one edge, stage 31 after 31 more
// - latch load low: latch transparent, copies shift register
// - latch load high: latch holds, shifting leaves switches alone
// - last stage drives serial output for daisy chaining
`timescale 1ns/100ps
module serial_switch_latch_control (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  input  wire logic        latch_load_n,
  input  wire logic        mode,
  output logic      [31:0] channel_switch,
  output logic             serial_out,
  output logic             push_ready,
  output logic             shift_overrun,
  output logic             bits_aligned
);

  // ==========================================================
  // serial clock edge detect
  logic sclk_prev_ff;
  logic nxt_sclk_prev;
  logic sclk_rise;

  always_comb
  begin
    nxt_sclk_prev = serial_clk;
    sclk_rise     = serial_clk && !sclk_prev_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_prev_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      sclk_prev_ff <= nxt_sclk_prev;
    end
  end

  // ==========================================================
  // sampled bit buffer
  logic fifo_in_valid;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_out_data;

  always_comb
  begin
    fifo_in_valid  = sclk_rise && !mode;
    // shift path is frozen while in global mode
    fifo_out_ready = !mode;
  end

  bit_fifo #(
    .WIDTH (switch_latch_pkg::FIFO_WIDTH),
    .DEPTH (switch_latch_pkg::FIFO_DEPTH)
  ) u_bit_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (fifo_in_valid),
    .in_ready  (push_ready),
    .in_data   (serial_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // shift register
  logic [31:0] shift_ff;
  logic [31:0] nxt_shift;
  logic        shift_step;

  always_comb
  begin
    shift_step = fifo_out_valid && fifo_out_ready;
    nxt_shift  = shift_ff;
    if (shift_step)
    begin
      nxt_shift = {shift_ff[switch_latch_pkg::LAST_STAGE-1:0], fifo_out_data};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_ff <= switch_latch_pkg::SHIFT_RESET;
    end
    else if (clk_en)
    begin
      shift_ff <= nxt_shift;
    end
  end

  // last stage out to the next device
  assign serial_out = shift_ff[switch_latch_pkg::LAST_STAGE];

  // ==========================================================
  // holding latch
  logic [31:0] latch_ff;
  logic [31:0] nxt_latch;

  always_comb
  begin
    nxt_latch = latch_ff;
    if (!latch_load_n)
    begin
      nxt_latch = shift_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_ff <= switch_latch_pkg::LATCH_RESET;
    end
    else if (clk_en)
    begin
      latch_ff <= nxt_latch;
    end
  end

  // ==========================================================
  // switch drive
  logic [31:0] switch_ff;
  logic [31:0] nxt_switch;

  genvar ch;
  generate
    for (ch = 0; ch < switch_latch_pkg::CHANNELS; ch++)
    begin : g_chan
      always_comb
      begin
        if (mode)
        begin
          nxt_switch[ch] = serial_in;
        end
        else
        begin
          nxt_switch[ch] = latch_ff[ch];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switch_ff <= switch_latch_pkg::SWITCH_RESET;
    end
    else if (clk_en)
    begin
      switch_ff <= nxt_switch;
    end
  end

  assign channel_switch = switch_ff;

  // ==========================================================
  // overrun flag and frame count
  logic       overrun_ff;
  logic       nxt_overrun;
  logic [4:0] count_ff;
  logic [4:0] nxt_count;
  logic       aligned_ff;
  logic       nxt_aligned;

  always_comb
  begin
    // a rising edge that finds the buffer full loses its bit
    nxt_overrun = overrun_ff;
    if (!latch_load_n)
    begin
      nxt_overrun = 1'b0;
    end
    if (fifo_in_valid && !push_ready)
    begin
      nxt_overrun = 1'b1;
    end
    nxt_count = count_ff;
    if (shift_step)
    begin
      nxt_count = count_ff + 5'h01;
    end
    nxt_aligned = (nxt_count == switch_latch_pkg::COUNT_RESET);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun_ff <= 1'b0;
      count_ff   <= switch_latch_pkg::COUNT_RESET;
      aligned_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      overrun_ff <= nxt_overrun;
      count_ff   <= nxt_count;
      aligned_ff <= nxt_aligned;
    end
  end

  assign shift_overrun = overrun_ff;
  assign bits_aligned  = aligned_ff;

endmodule

/* File: test/ssl_checker_assertions.sv */
`timescale 1ns/100ps
module ssl_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        serial_clk,
  input wire logic        serial_in,
  input wire logic        latch_load_n,
  input wire logic        mode,
  input wire logic [31:0] channel_switch,
  input wire logic        serial_out,
  input wire logic        push_ready,
  input wire logic        shift_overrun,
  input wire logic        bits_aligned
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence quiet;
    !serial_clk && !mode && clk_en;
  endsequence
  chk_global_level: assert property (
    mode && clk_en |=> channel_switch == {32{$past(serial_in)}}) else $error("global level");
  chk_latch_hold: assert property (
    latch_load_n && !mode && clk_en ##1 !mode && clk_en |=> $stable(channel_switch))
    else $error("latch hold");
  chk_frozen_state: assert property (
    !clk_en |=> $stable(channel_switch) && $stable(serial_out)) else $error("frozen");
  chk_idle_shift: assert property (
    quiet[*6] |-> $stable(serial_out)) else $error("idle shift");
  chk_idle_drained: assert property (
    quiet[*6] |-> push_ready) else $error("idle drained");
  chk_global_stall: assert property (
    mode && clk_en ##1 mode && clk_en |-> $stable(serial_out)) else $error("stall");
  chk_load_copy: assert property (
    (!latch_load_n && !mode && clk_en && !serial_clk)[*8] |-> channel_switch[31] == serial_out)
    else $error("load copy");
  chk_overrun_clear: assert property (
    mode && !latch_load_n && clk_en |=> !shift_overrun) else $error("overrun clear");
  cover property (mode && serial_in);
  cover property (!latch_load_n && !mode);
  cover property (!clk_en && bits_aligned);
  cover property (!bits_aligned && !mode);
endmodule
bind serial_switch_latch_control ssl_checker u_chk (
  .clk            (clk),
  .rst_n          (rst_n),
  .clk_en         (clk_en),
  .serial_clk     (serial_clk),
  .serial_in      (serial_in),
  .latch_load_n   (latch_load_n),
  .mode           (mode),
  .channel_switch (channel_switch),
  .serial_out     (serial_out),
  .push_ready     (push_ready),
  .shift_overrun  (shift_overrun),
  .bits_aligned   (bits_aligned)
);

/* File: test/host_model.sv */
`timescale 1ns/100ps
module host_model (
  input  wire logic clk,
  output logic      serial_clk,
  output logic      serial_in,
  output logic      latch_load_n
);
  initial {serial_clk, serial_in, latch_load_n} = 3'b001;
  // one data line of a chain that shares clock and latch load
  task automatic send(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk);
      #1 serial_in = w[i];
      @(posedge clk);
      #1 serial_clk = 1'b1;
      repeat (2) @(posedge clk);
      #1 serial_clk = 1'b0;
    end
    repeat (8) @(posedge clk);
    #1 serial_in = ~serial_in;
  endtask
  task automatic load();
    @(posedge clk);
    #1 latch_load_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 latch_load_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic set_in(input logic b);
    @(posedge clk);
    #1 serial_in = b;
  endtask
endmodule

/* File: test/tb_serial_switch_latch_control.sv */
`timescale 1ns/100ps
module tb_serial_switch_latch_control;
  logic        clk          = 1'b0;
  logic        rst_n        = 1'b0;
  logic        clk_en       = 1'b1;
  logic        mode         = 1'b0;
  logic        mon_go       = 1'b0;
  logic        serial_clk;
  logic        serial_in;
  logic        latch_load_n;
  logic        serial_out;
  logic        push_ready;
  logic        shift_overrun;
  logic        bits_aligned;
  logic [31:0] channel_switch;
  logic [31:0] w;
  logic [31:0] prev         = 32'h0000_0000;
  logic [31:0] exp_q[$];
  int          err_count    = 0;
  int          compares     = 0;

  always #2.5 clk = ~clk;

  serial_switch_latch_control u_dut (
    .clk            (clk),
    .rst_n          (rst_n),
    .clk_en         (clk_en),
    .serial_clk     (serial_clk),
    .serial_in      (serial_in),
    .latch_load_n   (latch_load_n),
    .mode           (mode),
    .channel_switch (channel_switch),
    .serial_out     (serial_out),
    .push_ready     (push_ready),
    .shift_overrun  (shift_overrun),
    .bits_aligned   (bits_aligned)
  );

  host_model u_host (
    .clk          (clk),
    .serial_clk   (serial_clk),
    .serial_in    (serial_in),
    .latch_load_n (latch_load_n)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // note the expected switches, let the launching edge pass, then let the monitor look
  task automatic expect_sw(input logic [31:0] v);
    exp_q.push_back(v);
    @(posedge clk);
    #1 mon_go = 1'b1;
    @(posedge clk);
    #1 mon_go = 1'b0;
  endtask

  always @(posedge clk)
  begin
    if (mon_go && exp_q.size() > 0)
    begin
      check(channel_switch, exp_q.pop_front());
    end
  end

  task automatic check_status(input logic so, input logic al);
    check({31'h0, serial_out}, {31'h0, so});
    check({31'h0, bits_aligned}, {31'h0, al});
    check({30'h0, push_ready, shift_overrun}, 32'h0000_0002);
  endtask

  task automatic release_reset(input int cycles);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (cycles) @(posedge clk);
    #1 check(channel_switch, 32'h0000_0000);
    check_status(1'b0, 1'b1);
    rst_n = 1'b1;
    prev  = 32'h0000_0000;
  endtask

  task automatic full_frame();
    w = $urandom();
    u_host.send(w, 32);
    expect_sw(prev);
    check_status(w[31], 1'b1);
    u_host.load();
    expect_sw(w);
    prev = w;
  endtask

  task automatic final_report();
    if (exp_q.size() != 0)
    begin
      err_count++;
    end
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial
  begin
    void'($urandom(53518));
    release_reset(12);
    for (int k = 0; k < 3; k++)
    begin
      full_frame();
    end
    // ==========================================================
    // partial frame, then its last bit
    w = $urandom();
    u_host.send(w, 31);
    check_status(prev[0], 1'b0);
    u_host.load();
    expect_sw({prev[0], w[30:0]});
    u_host.send({31'h0, w[31]}, 1);
    check_status(w[30], 1'b1);
    u_host.load();
    expect_sw({w[30:0], w[31]});
    prev = {w[30:0], w[31]};
    // ==========================================================
    // global mode
    @(posedge clk);
    #1 mode = 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      u_host.set_in(b[0]);
      expect_sw({32{b[0]}});
      u_host.load();
      expect_sw({32{b[0]}});
    end
    // ==========================================================
    // clock enable freeze
    @(posedge clk);
    #1 clk_en = 1'b0;
    u_host.set_in(1'b0);
    expect_sw(32'hffff_ffff);
    @(posedge clk);
    #1 clk_en = 1'b1;
    expect_sw(32'h0000_0000);
    @(posedge clk);
    #1 mode = 1'b0;
    expect_sw(prev);
    check_status(prev[31], 1'b1);
    // ==========================================================
    // reset in mid-run
    release_reset(2);
    full_frame();
    final_report();
  end
endmodule
